// file: inc/actuator_io_pkg.sv
package actuator_io_pkg;

    // I/O pattern codes
    localparam logic [2:0] PAT_STANDARD = 3'h0;
    localparam logic [2:0] PAT_TEACH = 3'h1;
    localparam logic [2:0] PAT_P256 = 3'h2;
    localparam logic [2:0] PAT_P512 = 3'h3;
    localparam logic [2:0] PAT_SEVEN = 3'h4;
    localparam logic [2:0] PAT_THREE = 3'h5;
    localparam logic [2:0] PAT_RESET = PAT_STANDARD;

    // Point address masks per pattern
    localparam logic [8:0] MASK_P64 = 9'h03F;
    localparam logic [8:0] MASK_P256 = 9'h0FF;
    localparam logic [8:0] MASK_P512 = 9'h1FF;

    // Start trigger, completion and input disable modes
    localparam logic START_LEVEL = 1'h0;
    localparam logic START_EDGE = 1'h1;
    localparam logic COMPLETE_HOLD = 1'h0;
    localparam logic COMPLETE_BAND = 1'h1;
    localparam logic INPUT_ENABLED = 1'h0;

    // Serial rate select codes
    localparam logic [1:0] RATE_9600 = 2'h0;
    localparam logic [1:0] RATE_19200 = 2'h1;
    localparam logic [1:0] RATE_38400 = 2'h2;
    localparam logic [1:0] RATE_115200 = 2'h3;
    localparam logic [1:0] RATE_RESET = RATE_38400;

    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS_DEF = CLK_HZ / MS_PER_S;
    localparam logic [7:0] TURNAROUND_MS_DEF = 8'h05;
    localparam logic [9:0] HALF_BIT_9600 = 10'(CLK_HZ / (2 * 9600));
    localparam logic [9:0] HALF_BIT_19200 = 10'(CLK_HZ / (2 * 19200));
    localparam logic [9:0] HALF_BIT_38400 = 10'(CLK_HZ / (2 * 38400));
    localparam logic [9:0] HALF_BIT_115200 = 10'(CLK_HZ / (2 * 115200));
    // 3.5 characters of 11 bits, counted in half bits
    localparam logic [9:0] SILENT_HALF_BITS = 10'h04D;
    localparam logic [3:0] SILENT_INTERVAL_MULTIPLIER_MAX = 4'hA;
    // Pin synchroniser reset levels; the serial line idles high
    localparam logic [24:0] PIN_IDLE = 25'h0000001;

    typedef enum logic [1:0] {
        MOVE_IDLE,
        MOVE_RUN,
        MOVE_DECEL
    } move_state_type;

endpackage

// file: verilog/actuator_io_interface_config.sv
`timescale 1ns/1ns
module actuator_io_interface_config #(
    parameter int CYCLES_PER_MS = actuator_io_pkg::CYCLES_PER_MS_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire logic [2:0] io_pattern_select,
    input wire logic io_function_flags,
    input wire logic pauseDisable,
    input wire logic servoOnDisable,
    input wire logic homeDisable,
    input wire logic modeDisable,
    input wire logic in_band_mode,
    input wire logic [1:0] serial_rate_select,
    input wire logic [7:0] reply_turnaround_delay,
    input wire logic [3:0] silent_interval_multiplier,
    // Controller pins
    input wire logic startPin,
    input wire logic [8:0] pointSelectPin,
    input wire logic [6:0] direct_start_input,
    input wire logic pausePin,
    input wire logic servoOnPin,
    input wire logic homePin,
    input wire logic modePin,
    input wire logic jogFwdPin,
    input wire logic jogRevPin,
    input wire logic teachStorePin,
    input wire logic serialRxPin,
    // Motion core status
    input wire logic targetReached,
    input wire logic inBand,
    input wire logic servoActive,
    input wire logic [6:0] atPosition,
    input wire logic zoneParamHit,
    input wire logic zoneTableHit,
    input wire logic replyDone,
    // Motion core commands
    output logic moveStart,
    output logic [8:0] moveTarget,
    output logic decelStop,
    output logic pauseCmd,
    output logic servoOnCmd,
    output logic homeCmd,
    output logic teachMode,
    output logic jogFwdCmd,
    output logic jogRevCmd,
    output logic teachStore,
    output logic pushHoldAllowed,
    output logic [9:0] halfBitCycles,
    // Controller outputs
    output logic [8:0] completed_point_code,
    output logic [6:0] per_position_complete,
    output logic position_complete_flag,
    output logic zoneParamOut,
    output logic zoneTableOut,
    output logic txEnable,
    output logic frameEnd
);
    import actuator_io_pkg::*;

    // Reset release
    logic [1:0] rstSync_q;
    logic rstN;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) rstSync_q <= 2'h0;
        else rstSync_q <= {rstSync_q[0], 1'h1};
    end
    assign rstN = rstSync_q[1];

    // Pin synchronisers, 25 pins
    localparam int NPIN = 25;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] pinMeta_q;
    logic [NPIN-1:0] pin_q;
    assign pinRaw = {startPin, pointSelectPin, direct_start_input, pausePin, servoOnPin,
                     homePin, modePin, jogFwdPin, jogRevPin, teachStorePin, serialRxPin};
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            // Idle levels, so no false line edge follows reset
            pinMeta_q <= PIN_IDLE;
            pin_q <= PIN_IDLE;
        end else begin
            pinMeta_q <= pinRaw;
            pin_q <= pinMeta_q;
        end
    end
    logic startS, pauseS, servoS, homeS, modeS, jogFS, jogRS, storeS, rxS;
    logic [8:0] pointS;
    logic [6:0] directS;
    assign {startS, pointS, directS, pauseS, servoS, homeS, modeS, jogFS, jogRS, storeS,
            rxS} = pin_q;

    // Previous pin levels for edge detection
    logic startPrev_q, storePrev_q, rxPrev_q;
    logic [6:0] directPrev_q;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            startPrev_q <= 1'h0;
            storePrev_q <= 1'h0;
            rxPrev_q <= 1'h1;
            directPrev_q <= 7'h00;
        end else begin
            startPrev_q <= startS;
            storePrev_q <= storeS;
            rxPrev_q <= rxS;
            directPrev_q <= directS;
        end
    end

    // Lowest asserted direct start wins
    function automatic logic [2:0] lowestSet(input logic [6:0] v);
        lowestSet = 3'h0;
        for (int i = 6; i >= 0; i--) begin
            if (v[i]) lowestSet = 3'(i);
        end
    endfunction

    // Pattern decode; codes 6 and 7 fall back to standard
    wire patTeach = (io_pattern_select == PAT_TEACH);
    wire patSeven = (io_pattern_select == PAT_SEVEN);
    wire patThree = (io_pattern_select == PAT_THREE);
    wire patDirect = patSeven || patThree;
    wire [8:0] pointMask = (io_pattern_select == PAT_P512) ? MASK_P512 :
                           (io_pattern_select == PAT_P256) ? MASK_P256 :
                           MASK_P64;
    wire zoneParamOn = !(patTeach || io_pattern_select == PAT_P256 ||
                         io_pattern_select == PAT_P512 || patDirect);
    wire zoneTableOn = !(io_pattern_select == PAT_P512 || patDirect);

    // Input disable selections
    wire pauseEff = (pauseDisable == INPUT_ENABLED) && pauseS;
    wire servoEff = (servoOnDisable == INPUT_ENABLED) ? servoS : 1'h1;
    wire homeEff = (homeDisable == INPUT_ENABLED) && homeS;
    wire modeEff = (modeDisable == INPUT_ENABLED) && modeS;
    wire teachEff = patTeach && modeEff;

    // Start qualification
    wire [6:0] directMask = patThree ? 7'h07 : 7'h7F;
    wire [6:0] directLive = directS & directMask;
    wire [6:0] directRise = directLive & ~directPrev_q;
    // Trigger mode is only looked at in seven-point; three-point always edge
    wire levelMode = patSeven && (io_function_flags == START_LEVEL);
    wire [6:0] directTrig = levelMode ? directLive : directRise;
    wire binaryTrig = startS && !startPrev_q && !teachEff;
    wire startTrig = patDirect ? ((|directTrig) && !teachEff) : binaryTrig;
    wire [2:0] directIdx = lowestSet(directTrig);
    wire [8:0] trigTarget = patDirect ? {6'h00, directIdx} : (pointS & pointMask);

    // Move sequencer
    move_state_type state_q, state_d;
    logic [8:0] target_q;
    logic levelHeld_q;
    logic doneValid_q;
    wire levelReleased = levelHeld_q && !directS[target_q[2:0]];
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            MOVE_IDLE: begin
                if (startTrig && servoEff && !pauseEff) state_d = MOVE_RUN;
            end
            MOVE_RUN: begin
                if (targetReached) state_d = MOVE_IDLE;
                else if (levelReleased) state_d = MOVE_DECEL;
            end
            MOVE_DECEL: begin
                if (targetReached) state_d = MOVE_IDLE;
            end
        endcase
        // Servo off aborts any motion
        if (!servoEff) state_d = MOVE_IDLE;
    end
    wire launching = (state_q == MOVE_IDLE) && (state_d == MOVE_RUN);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_q <= MOVE_IDLE;
            target_q <= 9'h000;
            levelHeld_q <= 1'h0;
            doneValid_q <= 1'h0;
        end else begin
            state_q <= state_d;
            if (launching) begin
                target_q <= trigTarget;
                levelHeld_q <= levelMode;
            end
            // Decelerated stop counts as finished; new launch clears completion
            if (launching) doneValid_q <= 1'h0;
            else if (state_q != MOVE_IDLE && state_d == MOVE_IDLE && servoEff) begin
                doneValid_q <= 1'h1;
            end
        end
    end

    // Completion outputs
    wire holdOk = doneValid_q && servoActive;
    wire bandOk = doneValid_q && inBand;
    wire completeOn = (in_band_mode == COMPLETE_BAND) ? bandOk : holdOk;
    wire [6:0] directDone = completeOn ? (7'h01 << target_q[2:0]) : 7'h00;
    // Three-point outputs follow the actual position like cylinder switches
    wire [6:0] perPosD = patThree ? (atPosition & 7'h07) :
                         (patSeven ? directDone : 7'h00);
    wire [8:0] pointCodeD = (completeOn && !patDirect) ? target_q : 9'h000;
    wire pendD = patThree ? (completeOn || |(atPosition & 7'h07)) : completeOn;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            moveStart <= 1'h0;
            moveTarget <= 9'h000;
            decelStop <= 1'h0;
            pauseCmd <= 1'h0;
            servoOnCmd <= 1'h0;
            homeCmd <= 1'h0;
            teachMode <= 1'h0;
            jogFwdCmd <= 1'h0;
            jogRevCmd <= 1'h0;
            teachStore <= 1'h0;
            pushHoldAllowed <= 1'h1;
            completed_point_code <= 9'h000;
            per_position_complete <= 7'h00;
            position_complete_flag <= 1'h0;
            zoneParamOut <= 1'h0;
            zoneTableOut <= 1'h0;
        end else begin
            moveStart <= launching;
            if (launching) moveTarget <= trigTarget;
            decelStop <= (state_d == MOVE_DECEL);
            pauseCmd <= pauseEff;
            servoOnCmd <= servoEff;
            homeCmd <= homeEff && (state_q == MOVE_IDLE);
            teachMode <= teachEff;
            jogFwdCmd <= patTeach && jogFS && (state_q == MOVE_IDLE);
            jogRevCmd <= patTeach && jogRS && (state_q == MOVE_IDLE);
            teachStore <= teachEff && storeS && !storePrev_q;
            pushHoldAllowed <= !patThree;
            completed_point_code <= pointCodeD;
            per_position_complete <= perPosD;
            position_complete_flag <= pendD;
            zoneParamOut <= zoneParamOn && zoneParamHit;
            zoneTableOut <= zoneTableOn && zoneTableHit;
        end
    end

    // Serial timing: half-bit period from the rate select
    wire [9:0] halfBitD = (serial_rate_select == RATE_9600) ? HALF_BIT_9600 :
                          (serial_rate_select == RATE_19200) ? HALF_BIT_19200 :
                          (serial_rate_select == RATE_115200) ? HALF_BIT_115200 :
                          HALF_BIT_38400;
    // Out-of-range multipliers clamp to the top value
    wire [3:0] mult = (silent_interval_multiplier > SILENT_INTERVAL_MULTIPLIER_MAX) ? SILENT_INTERVAL_MULTIPLIER_MAX :
                      silent_interval_multiplier;
    wire [3:0] multEff = (mult == 4'h0) ? 4'h1 : mult;
    wire [13:0] silentLimit = 14'(SILENT_HALF_BITS * multEff);

    logic [9:0] halfCnt_q;
    logic [13:0] silentCnt_q;
    logic frameActive_q;
    wire rxEdge = rxS ^ rxPrev_q;
    wire halfTick = (halfCnt_q >= halfBitD - 10'h001);
    wire silentHit = frameActive_q && (silentCnt_q >= silentLimit);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            halfCnt_q <= 10'h000;
            silentCnt_q <= 14'h0000;
            frameActive_q <= 1'h0;
            frameEnd <= 1'h0;
            halfBitCycles <= HALF_BIT_38400;
        end else begin
            halfBitCycles <= halfBitD;
            frameEnd <= silentHit;
            if (rxEdge || halfTick) halfCnt_q <= 10'h000;
            else halfCnt_q <= halfCnt_q + 10'h001;
            if (rxEdge || !rxS) silentCnt_q <= 14'h0000;
            else if (halfTick && !silentHit) silentCnt_q <= silentCnt_q + 14'h0001;
            if (rxEdge) frameActive_q <= 1'h1;
            else if (silentHit) frameActive_q <= 1'h0;
        end
    end

    // Reply turnaround: ms prescaler and delay counter
    logic [15:0] msPre_q;
    logic [7:0] msCnt_q;
    logic waiting_q;
    wire msTick = (msPre_q == 16'(CYCLES_PER_MS - 1));
    wire delayMet = (msCnt_q >= reply_turnaround_delay);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            msPre_q <= 16'h0000;
            msCnt_q <= 8'h00;
            waiting_q <= 1'h0;
            txEnable <= 1'h0;
        end else begin
            if (silentHit || msTick) msPre_q <= 16'h0000;
            else msPre_q <= msPre_q + 16'h0001;
            if (silentHit) begin
                waiting_q <= 1'h1;
                msCnt_q <= 8'h00;
            end else if (waiting_q && delayMet) begin
                waiting_q <= 1'h0;
            end else if (waiting_q && msTick) begin
                msCnt_q <= msCnt_q + 8'h01;
            end
            // New traffic on the line also withdraws the driver
            if (waiting_q && delayMet && !silentHit) txEnable <= 1'h1;
            else if (replyDone || rxEdge || silentHit) txEnable <= 1'h0;
        end
    end

endmodule // actuator_io_interface_config

// file: tb/actuator_io_interface_config_assertions.sv
`timescale 1ns/1ns
module actuator_io_interface_config_assertions
    import actuator_io_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
    // Clock, reset, settings and motion core status
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] io_pattern_select,
    input wire logic pauseDisable,
    input wire logic servoOnDisable,
    input wire logic modeDisable,
    input wire logic in_band_mode,
    input wire logic [1:0] serial_rate_select,
    input wire logic [7:0] reply_turnaround_delay,
    input wire logic inBand,
    input wire logic servoActive,
    // Watched outputs
    input wire logic moveStart,
    input wire logic pauseCmd,
    input wire logic servoOnCmd,
    input wire logic teachMode,
    input wire logic pushHoldAllowed,
    input wire logic [9:0] halfBitCycles,
    input wire logic position_complete_flag,
    input wire logic zoneParamOut,
    input wire logic zoneTableOut,
    input wire logic txEnable,
    input wire logic frameEnd
);
    localparam logic [9:0] HB [4] = '{HALF_BIT_9600, HALF_BIT_19200, HALF_BIT_38400,
        HALF_BIT_115200};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_push;
        $stable(io_pattern_select) [*2] |-> pushHoldAllowed == (io_pattern_select != PAT_THREE);
    endproperty
    a_push: assert property (p_push) else $error("push permission wrong for pattern");
    property p_rate; halfBitCycles == HB[$past(serial_rate_select)]; endproperty
    a_rate: assert property (p_rate) else $error("bit period wrong for rate");
    property p_pause; pauseDisable [*2] |-> !pauseCmd; endproperty
    a_pause: assert property (p_pause) else $error("pause passed while disabled");
    property p_servo; servoOnDisable [*2] |-> servoOnCmd; endproperty
    a_servo: assert property (p_servo) else $error("servo not forced on");
    property p_mode; modeDisable [*2] |-> !teachMode; endproperty
    a_mode: assert property (p_mode) else $error("teach mode while disabled");
    property p_p512;
        (io_pattern_select == PAT_P512) [*2] |-> !(zoneParamOut || zoneTableOut);
    endproperty
    a_p512: assert property (p_p512) else $error("zone output in 512 pattern");
    property p_hold;
        (!in_band_mode && !servoActive && io_pattern_select != PAT_THREE) [*2]
            |-> !position_complete_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("complete with servo off");
    property p_band;
        (in_band_mode && !inBand && io_pattern_select != PAT_THREE) [*2]
            |-> !position_complete_flag;
    endproperty
    a_band: assert property (p_band) else $error("complete outside band");
    // A zero delay setting may answer at once
    property p_turn; frameEnd && reply_turnaround_delay != 8'h00 |=> !txEnable [*8]; endproperty
    a_turn: assert property (p_turn) else $error("transmitter on too early");

    c_move: cover property (moveStart);
    c_frame: cover property (frameEnd);
    c_tx: cover property ($rose(txEnable));
endmodule // actuator_io_interface_config_assertions

bind actuator_io_interface_config actuator_io_interface_config_assertions #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
) i_checker (
    .clk, .rst_n, .io_pattern_select, .pauseDisable, .servoOnDisable, .modeDisable,
    .in_band_mode, .serial_rate_select, .reply_turnaround_delay, .inBand, .servoActive,
    .moveStart, .pauseCmd, .servoOnCmd, .teachMode, .pushHoldAllowed, .halfBitCycles,
    .position_complete_flag, .zoneParamOut, .zoneTableOut, .txEnable, .frameEnd
);

// file: tb/plc_partner_model.sv
`timescale 1ns/1ns
module plc_partner_model (
    // Clock
    input wire logic clk,
    // From block
    input wire logic moveStart,
    input wire logic decelStop,
    input wire logic txEnable,
    input wire logic [9:0] halfBitCycles,
    input wire logic sendReq,
    // To block
    output logic targetReached = 1'b0,
    output logic replyDone = 1'b0,
    output logic serialRxPin = 1'b1
);
    int left = 0;
    int txAge = 0;
    // Moves last 60 cycles; a stop cuts to 20 so the stop stays visible
    always @(posedge clk) begin
        targetReached <= left == 1;
        if (moveStart) begin
            left <= 60;
        end else if (decelStop && left > 20) begin
            left <= 20;
        end else if (left > 0) begin
            left <= left - 1;
        end
        txAge <= txEnable ? txAge + 1 : 0;
        replyDone <= txAge == 30;
    end
    // Start bit and eight zero bits, then idle high
    always @(posedge sendReq) begin
        serialRxPin = 1'b0;
        repeat (18 * halfBitCycles) @(posedge clk);
        #2 serialRxPin = 1'b1;
    end
endmodule // plc_partner_model

// file: tb/tb_actuator_io_interface_config.sv
`timescale 1ns/1ns
module tb_actuator_io_interface_config;
    import actuator_io_pkg::*;
    localparam int CPM = 10;
    localparam logic [8:0] MASK [4] = '{MASK_P64, MASK_P64, MASK_P256, MASK_P512};
    localparam logic [9:0] HB [4] = '{HALF_BIT_9600, HALF_BIT_19200, HALF_BIT_38400,
        HALF_BIT_115200};
    logic clk, rst_n, io_function_flags, pauseDisable, servoOnDisable, homeDisable, modeDisable;
    logic in_band_mode, startPin, pausePin, servoOnPin, homePin, modePin, jogFwdPin, jogRevPin;
    logic teachStorePin, inBand, servoActive, zoneParamHit, zoneTableHit, sendReq;
    logic [2:0] io_pattern_select;
    logic [1:0] serial_rate_select;
    logic [7:0] reply_turnaround_delay;
    logic [3:0] silent_interval_multiplier;
    logic [8:0] pointSelectPin, moveTarget, completed_point_code;
    logic [6:0] direct_start_input, atPosition, per_position_complete;
    logic serialRxPin, targetReached, replyDone, moveStart, decelStop, pauseCmd, servoOnCmd;
    logic homeCmd, teachMode, jogFwdCmd, jogRevCmd, teachStore, pushHoldAllowed, frameEnd;
    logic position_complete_flag, zoneParamOut, zoneTableOut, txEnable;
    logic [9:0] halfBitCycles;
    int err_total = 0;
    int n_checks = 0;

    always #50 clk = ~clk;

    actuator_io_interface_config #(.CYCLES_PER_MS(CPM)) i_actuator_io_interface_config (
        .clk, .rst_n, .io_pattern_select, .io_function_flags, .pauseDisable, .servoOnDisable,
        .homeDisable, .modeDisable, .in_band_mode, .serial_rate_select, .reply_turnaround_delay,
        .silent_interval_multiplier, .startPin, .pointSelectPin, .direct_start_input, .pausePin,
        .servoOnPin, .homePin, .modePin, .jogFwdPin, .jogRevPin, .teachStorePin, .serialRxPin,
        .targetReached, .inBand, .servoActive, .atPosition, .zoneParamHit, .zoneTableHit,
        .replyDone, .moveStart, .moveTarget, .decelStop, .pauseCmd, .servoOnCmd, .homeCmd,
        .teachMode, .jogFwdCmd, .jogRevCmd, .teachStore, .pushHoldAllowed, .halfBitCycles,
        .completed_point_code, .per_position_complete, .position_complete_flag, .zoneParamOut,
        .zoneTableOut, .txEnable, .frameEnd);
    plc_partner_model i_plc_partner_model (.clk, .moveStart, .decelStop, .txEnable,
        .halfBitCycles, .sendReq, .targetReached, .replyDone, .serialRxPin);

    task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Bounded wait; n returns the cycles spent
    task automatic waitFor(ref logic s, input logic v, input int lim, output int n);
        for (n = 0; n < lim && s !== v; n++) begin
            tick(1);
        end
        if (s !== v) begin
            err_total++;
            report_and_stop();
        end
    endtask

    task automatic t_rates;
        for (int i = 0; i < 4; i++) begin
            serial_rate_select = 2'(i);
            tick(3);
            chk("halfBit", halfBitCycles, HB[i]);
        end
        serial_rate_select = RATE_38400;
        $display("rates done");
    endtask

    task automatic t_binary;
        int n;
        for (int p = 0; p < 4; p++) begin
            io_pattern_select = 3'(p);
            startPin = 1'b1;
            waitFor(moveStart, 1'b1, 20, n);
            chk("target", moveTarget, MASK[p]);
            waitFor(targetReached, 1'b1, 100, n);
            startPin = 1'b0;
            tick(4);
            chk("point", completed_point_code, MASK[p]);
            chk("flag", position_complete_flag, 1'b1);
            chk("zoneParam", zoneParamOut, p == 0);
            chk("zoneTable", zoneTableOut, p != 3);
            servoActive = 1'b0;
            tick(3);
            chk("holdOff", position_complete_flag, 1'b0);
            servoActive = 1'b1;
        end
        $display("binary done");
    endtask

    task automatic t_band;
        {in_band_mode, servoActive} = 2'h2;
        tick(3);
        chk("bandOn", position_complete_flag, 1'b1);
        inBand = 1'b0;
        tick(3);
        chk("bandOff", position_complete_flag, 1'b0);
        {in_band_mode, servoActive, inBand} = 3'h3;
        $display("band done");
    endtask

    task automatic t_seven;
        int n;
        io_pattern_select = PAT_SEVEN;
        for (int m = 0; m < 2; m++) begin
            io_function_flags = m[0];
            direct_start_input = 7'h0C;
            waitFor(moveStart, 1'b1, 20, n);
            chk("directTarget", moveTarget, 9'h002);
            tick(10);
            direct_start_input = 7'h00;
            tick(5);
            chk("decel", decelStop, m == 0);
            waitFor(targetReached, 1'b1, 100, n);
            tick(4);
            chk("perPos", per_position_complete, 7'h04);
        end
        io_pattern_select = PAT_THREE;
        atPosition = 7'h02;
        tick(4);
        chk("detect", per_position_complete, 7'h02);
        chk("push", pushHoldAllowed, 1'b0);
        atPosition = 7'h00;
        $display("direct done");
    endtask

    task automatic t_inputs;
        io_pattern_select = PAT_TEACH;
        {modePin, jogFwdPin, jogRevPin} = 3'h7;
        tick(5);
        chk("teach", teachMode, 1'b1);
        chk("jogTeach", jogFwdCmd, 1'b1);
        chk("jogRevTeach", jogRevCmd, 1'b1);
        teachStorePin = 1'b1;
        tick(3);
        chk("store", teachStore, 1'b1);
        tick(1);
        chk("storePulse", teachStore, 1'b0);
        teachStorePin = 1'b0;
        modeDisable = 1'b1;
        tick(5);
        chk("teachOff", teachMode, 1'b0);
        chk("jogPos", jogFwdCmd, 1'b1);
        {modePin, jogFwdPin, jogRevPin, modeDisable, pausePin} = 5'h01;
        tick(5);
        chk("pause", pauseCmd, 1'b1);
        {pauseDisable, homePin} = 2'h3;
        tick(5);
        chk("pauseOff", pauseCmd, 1'b0);
        chk("home", homeCmd, 1'b1);
        {homeDisable, servoOnDisable, servoOnPin} = 3'h6;
        tick(5);
        chk("homeOff", homeCmd, 1'b0);
        chk("servoForced", servoOnCmd, 1'b1);
        {pausePin, pauseDisable, homePin, homeDisable, servoOnDisable} = '0;
        tick(5);
        chk("servoOff", servoOnCmd, 1'b0);
        servoOnPin = 1'b1;
        $display("inputs done");
    endtask

    task automatic t_serial;
        int n;
        int lo;
        serial_rate_select = RATE_115200;
        reply_turnaround_delay = 8'h02;
        for (int k = 0; k < 2; k++) begin
            silent_interval_multiplier = 4'(2 * k);
            lo = 77 * HALF_BIT_115200 * (k + 1);
            tick(2);
            sendReq = 1'b1;
            tick(1);
            sendReq = 1'b0;
            waitFor(serialRxPin, 1'b1, 2000, n);
            waitFor(frameEnd, 1'b1, 8000, n);
            chk("silent", n >= lo - 45 && n <= lo + 50, 1'b1);
            waitFor(txEnable, 1'b1, 100, n);
            chk("turnaround", n >= 2 * CPM && n <= 3 * CPM + 4, 1'b1);
            waitFor(txEnable, 1'b0, 100, n);
        end
        $display("serial done");
    endtask

    initial begin
        {io_function_flags, pauseDisable, servoOnDisable, homeDisable, modeDisable, in_band_mode,
            startPin, pausePin, homePin, modePin, jogFwdPin, jogRevPin, teachStorePin,
            sendReq} = '0;
        {clk, rst_n, servoOnPin, servoActive, inBand, zoneParamHit, zoneTableHit} = 7'h1F;
        io_pattern_select = PAT_STANDARD;
        serial_rate_select = RATE_38400;
        reply_turnaround_delay = TURNAROUND_MS_DEF;
        silent_interval_multiplier = 4'h0;
        pointSelectPin = 9'h1FF;
        direct_start_input = 7'h00;
        atPosition = 7'h00;
        repeat (16) @(posedge clk);
        #2 rst_n = 1'b1;
        tick(4);
        chk("rateReset", halfBitCycles, HALF_BIT_38400);
        chk("pushReset", pushHoldAllowed, 1'b1);
        t_rates();
        t_binary();
        t_band();
        t_seven();
        t_inputs();
        t_serial();
        report_and_stop();
    end
endmodule // tb_actuator_io_interface_config
